// ===== rtl/lnfpa_frame.sv
// Frame handler of the slave node: header classification, checksum,
// identifier table, assignment service and its positive response.
// Assumes a byte receiver on mclk giving header and data bytes as pulses,
// the last byte of a frame flagged, and a byte sender draining tx_*.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Identifier, one to eight data, checksum
// - Diagnostic frames use data-only checksum
// - Other frames include identifier in checksum
// - Sum with end-around carry, then inverted
// - Two identifier parity bits are checked
// - Master sends header, one slave answers
// - Direct identifier from index 6 only triggers a read
// - Indirect read needs preceding preparing frame
// - Indirect answer carries own node address
// - Prepare-read sequence only for diagnostic identifiers
// - Preparing frame holds address and command
// - Reserved identifiers never used as dynamic
// - Assignment frame layout and classic checksum
// - Four codes stored from start index
// - Code zero unassigns the entry
// - Code 255 keeps the entry
// - Codes stored without parity check
// - Respond only if every request served
// - Four entries per frame, eleven total
// - Table starts unassigned after power-up
// - Address 127 reaches every slave
module lnfpa_frame (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [6:0] node_addr,
   input wire logic addr_valid,
   input wire logic hdr_valid,
   input wire logic [7:0] hdr_pid,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_last,
   output logic cmd_valid,
   output logic cmd_read,
   output logic [3:0] cmd_index,
   output logic [3:0] cmd_len,
   output logic [63:0] cmd_data,
   output logic [87:0] pid_table,
   output logic prep_pending
);
   typedef enum logic [1:0] {
      LNFPA_IDLE,
      LNFPA_RX,
      LNFPA_TX
   } lnfpa_state_t;

   typedef struct packed {
      lnfpa_state_t state;
      logic classic;
      logic [3:0] idx;
      logic [3:0] cnt;
      logic [7:0] acc;
      logic [lnfpa_pkg::MAX_DATA-1:0][7:0] buff;
      logic [lnfpa_pkg::NUM_IDS-1:0][7:0] tbl;
      logic prep;
      logic cmd_valid;
      logic cmd_read;
      logic [3:0] cmd_index;
      logic [3:0] cmd_len;
      logic [63:0] cmd_data;
   } lnfpa_frame_st_t;

   lnfpa_frame_st_t q;
   lnfpa_frame_st_t d;
   logic [lnfpa_pkg::NUM_IDS-1:0] hit_vec;
   logic [7:0] ck_in;
   logic [7:0] ck_sum;
   logic [7:0] resp_byte;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [8:0] fifo_out;

   // ==========================================================
   // Package constants must fit the fixed port widths
   if (lnfpa_pkg::NUM_IDS * 8 != 88 || lnfpa_pkg::MAX_DATA * 8 != 64
      || lnfpa_pkg::FIFO_WIDTH != 9 || lnfpa_pkg::NUM_IDS > 15)
   begin : g_bad_cfg
      $error("Package constants do not fit the port widths");
   end

   // ==========================================================
   // Parity of a protected identifier
   function automatic logic pid_ok(input logic [7:0] p);
      pid_ok = (p[6] == (p[0] ^ p[1] ^ p[2] ^ p[4]))
         && (p[7] == !(p[1] ^ p[3] ^ p[4] ^ p[5]));
   endfunction

   // ==========================================================
   // Table lookup, one comparator per entry
   for (genvar i = 0; i < lnfpa_pkg::NUM_IDS; i++)
   begin : g_hit
      assign hit_vec[i] = (q.tbl[i] != lnfpa_pkg::PID_UNASSIGN) && (q.tbl[i] == hdr_pid);
   end

   // ==========================================================
   // Response bytes of the positive answer
   always_comb
   begin
      case (q.cnt)
         4'h0: resp_byte = {1'b0, node_addr};
         4'h1: resp_byte = lnfpa_pkg::PCI_POS_RESP;
         4'h2: resp_byte = lnfpa_pkg::RSID_ASSIGN;
         lnfpa_pkg::RESP_LAST: resp_byte = ~q.acc;
         default: resp_byte = lnfpa_pkg::RESP_FILL;
      endcase
   end

   assign ck_in = (q.state == LNFPA_TX) ? resp_byte : rx_data;

   lnfpa_cksum u_cksum (
      .acc(q.acc),
      .data(ck_in),
      .sum(ck_sum)
   );

   // ==========================================================
   // Frame sequencing
   always_comb
   begin
      logic hit;
      logic [3:0] hit_idx;
      logic nad_ok;
      logic all_ok;
      logic [8:0] slot;
      logic [7:0] code;
      d = q;
      hit = 1'b0;
      hit_idx = 4'h0;
      nad_ok = 1'b0;
      all_ok = 1'b1;
      slot = 9'h000;
      code = 8'h00;
      fifo_in_valid = 1'b0;
      d.cmd_valid = 1'b0;
      for (int i = lnfpa_pkg::NUM_IDS - 1; i >= 0; i--)
      begin
         if (hit_vec[i])
         begin
            hit = 1'b1;
            hit_idx = 4'(i);
         end
      end
      case (q.state)
         LNFPA_IDLE:
         begin
            // Node stays silent until its address is known
            if (hdr_valid && addr_valid)
            begin
               // any other header breaks the pairing
               d.prep = 1'b0;
               d.acc = lnfpa_pkg::ACC_RESET;
               d.cnt = 4'h0;
               if (!pid_ok(hdr_pid))
               begin
                  d.state = LNFPA_IDLE;
               end
               else if (hdr_pid == lnfpa_pkg::PID_DIAG_RESP)
               begin
                  // only right after our preparing frame
                  if (q.prep)
                  begin
                     d.state = LNFPA_TX;
                  end
               end
               else if (hdr_pid == lnfpa_pkg::PID_DIAG_REQ)
               begin
                  // identifier kept out of the sum
                  d.classic = 1'b1;
                  d.state = LNFPA_RX;
               end
               else if (hit && hdr_pid[5:0] < lnfpa_pkg::ID_RESERVED_LO)
               begin
                  d.idx = hit_idx;
                  if (hit_idx >= lnfpa_pkg::READ_FIRST_IDX)
                  begin
                     d.cmd_valid = 1'b1;
                     d.cmd_read = 1'b1;
                     d.cmd_index = hit_idx;
                     d.cmd_len = 4'h0;
                  end
                  else
                  begin
                     d.classic = 1'b0;
                     d.acc = hdr_pid;
                     d.state = LNFPA_RX;
                  end
               end
            end
         end
         LNFPA_RX:
         begin
            if (rx_valid && rx_last)
            begin
               d.state = LNFPA_IDLE;
               if (q.cnt != 4'h0 && (~q.acc) == rx_data)
               begin
                  if (q.classic)
                  begin
                     nad_ok = (q.buff[0] == {1'b0, node_addr})
                        || (q.buff[0] == lnfpa_pkg::NAD_BCAST);
                     if (nad_ok && q.cnt == lnfpa_pkg::ASSIGN_LEN
                        && q.buff[1] == lnfpa_pkg::PCI_ASSIGN
                        && q.buff[2] == lnfpa_pkg::SID_ASSIGN)
                     begin
                        for (int k = 0; k < 4; k++)
                        begin
                           code = q.buff[4+k];
                           slot = {1'b0, q.buff[3]} + 9'(k);
                           if (code != lnfpa_pkg::PID_KEEP)
                           begin
                              if (slot < 9'(lnfpa_pkg::NUM_IDS))
                              begin
                                 d.tbl[slot[3:0]] = code;
                              end
                              else
                              begin
                                 all_ok = 1'b0;
                              end
                           end
                        end
                        d.prep = all_ok;
                     end
                  end
                  else
                  begin
                     d.cmd_valid = 1'b1;
                     d.cmd_read = 1'b0;
                     d.cmd_index = q.idx;
                     d.cmd_len = q.cnt;
                     d.cmd_data = q.buff;
                  end
               end
            end
            else if (rx_valid)
            begin
               // more than eight data bytes drop the frame
               if (q.cnt == 4'(lnfpa_pkg::MAX_DATA))
               begin
                  d.state = LNFPA_IDLE;
               end
               else
               begin
                  d.buff[q.cnt[2:0]] = rx_data;
                  d.cnt = q.cnt + 4'h1;
                  d.acc = ck_sum;
               end
            end
         end
         LNFPA_TX:
         begin
            // Sender stall simply holds the answer in place
            fifo_in_valid = 1'b1;
            if (fifo_in_ready)
            begin
               d.acc = ck_sum;
               d.cnt = q.cnt + 4'h1;
               if (q.cnt == lnfpa_pkg::RESP_LAST)
               begin
                  d.state = LNFPA_IDLE;
               end
            end
         end
         default:
         begin
            d.state = LNFPA_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q <= '0;
         q.state <= LNFPA_IDLE;
         q.tbl <= {lnfpa_pkg::NUM_IDS{lnfpa_pkg::TBL_RESET}};
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // Answer buffer toward the byte sender
   lnfpa_fifo #(
      .WIDTH(lnfpa_pkg::FIFO_WIDTH),
      .DEPTH(lnfpa_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data({q.cnt == lnfpa_pkg::RESP_LAST, resp_byte}),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(fifo_out)
   );

   assign tx_data = fifo_out[7:0];
   assign tx_last = fifo_out[8];
   assign cmd_valid = q.cmd_valid;
   assign cmd_read = q.cmd_read;
   assign cmd_index = q.cmd_index;
   assign cmd_len = q.cmd_len;
   assign cmd_data = q.cmd_data;
   assign pid_table = q.tbl;
   assign prep_pending = q.prep;
endmodule
`default_nettype wire

// ===== rtl/lnfpa_pkg.sv
// Constants shared by the frame handler of the single-wire slave link.
// Assumes a byte-level receiver/transmitter on the same 100 MHz clock.
package lnfpa_pkg;
   // ==========================================================
   // Frame shape
   localparam int unsigned MAX_DATA = 8;
   localparam int unsigned NUM_IDS = 11;
   localparam logic [3:0] READ_FIRST_IDX = 4'h6;
   localparam logic [3:0] RESP_LAST = 4'h8;
   localparam logic [3:0] ASSIGN_LEN = 4'h8;
   // ==========================================================
   // Reserved identifiers and diagnostic codes
   localparam logic [7:0] PID_DIAG_REQ = 8'h3c;
   localparam logic [7:0] PID_DIAG_RESP = 8'h7d;
   localparam logic [5:0] ID_RESERVED_LO = 6'h3c;
   localparam logic [7:0] NAD_BCAST = 8'h7f;
   localparam logic [7:0] PCI_ASSIGN = 8'h06;
   localparam logic [7:0] SID_ASSIGN = 8'hb7;
   localparam logic [7:0] PCI_POS_RESP = 8'h01;
   localparam logic [7:0] RSID_ASSIGN = 8'hf7;
   localparam logic [7:0] RESP_FILL = 8'hff;
   localparam logic [7:0] PID_UNASSIGN = 8'h00;
   localparam logic [7:0] PID_KEEP = 8'hff;
   // ==========================================================
   // Values after reset and answer buffer size
   localparam logic [7:0] TBL_RESET = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned FIFO_WIDTH = 9;
endpackage

// ===== rtl/lnfpa_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes both sides on mclk; depth a power of two.
`timescale 1ns/10ps
`default_nettype none
module lnfpa_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 4
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ==========================================================
   // Parameter check
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
   begin : g_bad
      $error("FIFO depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic vld;
      logic [WIDTH-1:0] hd;
   } lnfpa_fifo_st_t;

   lnfpa_fifo_st_t q;
   lnfpa_fifo_st_t d;
   logic push;
   logic pop;

   // ==========================================================
   // Next state
   always_comb
   begin
      d = q;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push)
      begin
         d.mem[q.wp] = in_data;
         d.wp = q.wp + 1'b1;
      end
      if (pop)
      begin
         d.rp = q.rp + 1'b1;
      end
      if (push && !pop)
      begin
         d.cnt = q.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         d.cnt = q.cnt - 1'b1;
      end
      // Head and valid registered so the sender sees flop outputs
      d.vld = (d.cnt != '0);
      d.hd = d.mem[d.rp];
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // Full holds off the writer, so back-pressure reaches the source
   assign in_ready = (q.cnt != DEPTH[AW:0]);
   assign out_valid = q.vld;
   assign out_data = q.hd;
endmodule
`default_nettype wire

// ===== rtl/lnfpa_cksum.sv
// One step of the link checksum: 8-bit add with end-around carry.
// Purely combinational; the caller holds the running value.
`timescale 1ns/10ps
`default_nettype none
module lnfpa_cksum (
   input wire logic [7:0] acc,
   input wire logic [7:0] data,
   output logic [7:0] sum
);
   logic [8:0] raw;

   // ==========================================================
   // Carry folded back into bit 0
   always_comb
   begin
      raw = {1'b0, acc} + {1'b0, data};
      sum = raw[7:0] + {7'h00, raw[8]};
   end
endmodule
`default_nettype wire

// ===== bench/lnfpa_frame_assertions.sv
// Checker of the frame handler, watching its ports only.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module lnfpa_frame_chk (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic addr_valid,
   input wire logic hdr_valid,
   input wire logic [7:0] hdr_pid,
   input wire logic rx_valid,
   input wire logic rx_last,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic cmd_valid,
   input wire logic cmd_read,
   input wire logic [3:0] cmd_index,
   input wire logic [3:0] cmd_len,
   input wire logic [87:0] pid_table,
   input wire logic prep_pending
);
   // ====================
   // Properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_read_trig;
      cmd_valid && cmd_read |-> $past(hdr_valid) && cmd_len == 4'h0 && cmd_index >= 4'h6;
   endproperty
   a_read_trig: assert property (p_read_trig) else $error("read trigger wrong");
   property p_write_cmd;
      cmd_valid && !cmd_read |-> $past(rx_valid && rx_last) && cmd_index < 4'h6
         && cmd_len >= 4'h1 && cmd_len <= 4'h8;
   endproperty
   a_write_cmd: assert property (p_write_cmd) else $error("write command wrong");
   // Previous frame may still be signalling, so its last cycle is excluded
   property p_parity;
      hdr_valid && addr_valid && !$past(rx_valid)
         && hdr_pid[6] != (hdr_pid[0] ^ hdr_pid[1] ^ hdr_pid[2] ^ hdr_pid[4]) |=> !cmd_valid;
   endproperty
   a_parity: assert property (p_parity) else $error("bad parity accepted");
   property p_prep_rise;
      $rose(prep_pending) |-> $past(rx_valid && rx_last);
   endproperty
   a_prep_rise: assert property (p_prep_rise) else $error("prepared without frame");
   property p_prep_hold;
      prep_pending && !hdr_valid |=> prep_pending;
   endproperty
   a_prep_hold: assert property (p_prep_hold) else $error("prepare lost");
   property p_tbl;
      !$stable(pid_table) |-> $past(rx_valid && rx_last);
   endproperty
   a_tbl: assert property (p_tbl) else $error("table changed outside frame");
   property p_tx_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("answer byte dropped");
   property p_tx_end;
      tx_valid && tx_ready && tx_last |=> !tx_valid;
   endproperty
   a_tx_end: assert property (p_tx_end) else $error("bytes after checksum");
   property p_resp;
      hdr_valid && hdr_pid == 8'h7d && prep_pending && addr_valid |-> ##[1:4] tx_valid;
   endproperty
   a_resp: assert property (p_resp) else $error("answer missing");
endmodule
bind lnfpa_frame lnfpa_frame_chk u_chk (
   .mclk(mclk), .reset_n(reset_n), .addr_valid(addr_valid), .hdr_valid(hdr_valid),
   .hdr_pid(hdr_pid), .rx_valid(rx_valid), .rx_last(rx_last), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .cmd_valid(cmd_valid),
   .cmd_read(cmd_read), .cmd_index(cmd_index), .cmd_len(cmd_len),
   .pid_table(pid_table), .prep_pending(prep_pending)
);
`default_nettype wire

// ===== bench/lnfpa_master.sv
// Bus master model: sends headers and frames, drains the answer.
// Assumes mclk from the bench; drives just after rising edges.
`timescale 1ns/10ps
`default_nettype none
module lnfpa_master (
   input wire logic mclk,
   output logic hdr_valid,
   output logic [7:0] hdr_pid,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last,
   output logic tx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last
);
   logic [8:0] got[$];
   initial
   begin
      hdr_valid = 1'b0;
      hdr_pid = 8'h00;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
      tx_ready = 1'b1;
   end
   always @(posedge mclk)
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         got.push_back({tx_last, tx_data});
   function automatic logic [7:0] cks(input logic [7:0] s0, input logic [7:0] d[$]);
      logic [8:0] s;
      s = {1'b0, s0};
      foreach (d[i])
      begin
         s = s[7:0] + d[i];
         s = s[7:0] + s[8];
      end
      return ~s[7:0];
   endfunction
   task automatic rdy(input logic v);
      @(posedge mclk);
      #1;
      tx_ready = v;
   endtask
   // Released lines show the inverse so a stale value never matches
   task automatic hdr(input logic [7:0] pid);
      @(posedge mclk);
      #1;
      hdr_valid = 1'b1;
      hdr_pid = pid;
      @(posedge mclk);
      #1;
      hdr_valid = 1'b0;
      hdr_pid = ~pid;
   endtask
   task automatic put(input logic [7:0] b, input logic l);
      rx_valid = 1'b1;
      rx_data = b;
      rx_last = l;
      @(posedge mclk);
      #1;
   endtask
   task automatic send(input logic [7:0] pid, input logic [7:0] d[$], input bit enh);
      logic [7:0] ck;
      ck = cks(enh ? pid : 8'h00, d);
      hdr(pid);
      foreach (d[i])
         put(d[i], 1'b0);
      put(ck, 1'b1);
      rx_valid = 1'b0;
      rx_last = 1'b0;
      rx_data = ~ck;
   endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench of the frame handler with a master model.
// Assumes a 100 MHz clock; node address 5, later 9, driven by the bench.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic mclk;
   logic reset_n;
   logic hdr_valid, rx_valid, rx_last, tx_valid, tx_ready, tx_last;
   logic [7:0] hdr_pid, rx_data, tx_data;
   logic cmd_valid, cmd_read, prep_pending;
   logic [3:0] cmd_index, cmd_len;
   logic [63:0] cmd_data;
   logic [87:0] pid_table;
   logic [6:0] node_addr;
   logic addr_valid;
   int fails, checked, ncmd;
   lnfpa_master m (.mclk(mclk), .hdr_valid(hdr_valid), .hdr_pid(hdr_pid),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));
   lnfpa_frame dut (.mclk(mclk), .reset_n(reset_n), .node_addr(node_addr),
      .addr_valid(addr_valid),
      .hdr_valid(hdr_valid), .hdr_pid(hdr_pid), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .tx_last(tx_last), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
      .cmd_index(cmd_index), .cmd_len(cmd_len), .cmd_data(cmd_data),
      .pid_table(pid_table), .prep_pending(prep_pending));
   // ====================
   // Helpers
   always @(posedge mclk)
      if (cmd_valid === 1'b1)
         ncmd++;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input bit ok, input string msg);
      checked++;
      if (!ok)
      begin
         fails++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   function automatic logic [7:0] pp(input logic [5:0] i);
      return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
   endfunction
   function automatic logic [7:0] pk(input int k);
      return pp(6'h10 + 6'(k));
   endfunction
   // Codes packed first code lowest; waits one edge for the table
   task automatic asg(input logic [7:0] nad, input logic [3:0] st, input logic [31:0] c);
      m.send(8'h3c, '{nad, 8'h06, 8'hb7, {4'h0, st}, c[7:0], c[15:8], c[23:16], c[31:24]},
         1'b0);
      @(posedge mclk);
      #1;
   endtask
   task automatic ans();
      logic [7:0] e[$];
      e = '{{1'b0, node_addr}, 8'h01, 8'hf7, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
      e.push_back(m.cks(8'h00, e));
      for (int n = 0; n < 60 && m.got.size() < 9; n++)
         @(posedge mclk);
      chk(m.got.size() >= 9, "answer timeout");
      if (m.got.size() < 9)
         report_and_stop();
      foreach (e[i])
         chk(m.got[i] === {i == 8, e[i]}, "answer byte");
      m.got.delete();
   endtask
   task automatic quiet();
      repeat (20) @(posedge mclk);
      chk(m.got.size() == 0, "unexpected answer");
   endtask
   // ====================
   // Scenarios
   // Headers ignored until the address is known
   task automatic t_noaddr;
      asg(8'h05, 4'h0, {pk(3), pk(2), pk(1), pk(0)});
      chk(pid_table === 88'h0 && prep_pending === 1'b0, "no address");
      addr_valid = 1'b1;
   endtask
   task automatic t_assign;
      asg(8'h05, 4'h0, {pk(3), pk(2), pk(1), pk(0)});
      for (int k = 0; k < 4; k++)
         chk(pid_table[8*k+:8] === pk(k), "table entry");
      chk(prep_pending === 1'b1, "not prepared");
      m.hdr(8'h7d);
      ans();
   endtask
   task automatic t_keep;
      asg(8'h05, 4'h7, {pk(10), pk(9), pk(8), pk(7)});
      m.hdr(8'h7d);
      ans();
      asg(8'h7f, 4'h8, 32'hffff00ff);
      chk(pid_table[87:56] === {pk(10), 8'h00, pk(8), pk(7)}, "keep or clear");
      m.hdr(8'h7d);
      ans();
   endtask
   task automatic t_read;
      logic [7:0] q;
      q = pk(10) ^ 8'h40;
      ncmd = 0;
      m.hdr(pk(7));
      repeat (3) @(posedge mclk);
      chk(ncmd == 1 && cmd_read === 1'b1 && cmd_index === 4'h7 && cmd_len === 4'h0, "rd");
      m.hdr(pk(9));
      repeat (3) @(posedge mclk);
      chk(ncmd == 1, "cleared entry answered");
      asg(8'h05, 4'ha, {24'hffffff, q});
      chk(pid_table[87:80] === q, "code not stored");
      m.hdr(8'h7d);
      ans();
      m.hdr(q);
      repeat (3) @(posedge mclk);
      chk(ncmd == 1, "bad parity answered");
   endtask
   // A large first byte forces a carry in the sum
   task automatic t_write;
      ncmd = 0;
      m.send(pk(0), '{8'hf0, 8'h80, 8'h33}, 1'b1);
      repeat (3) @(posedge mclk);
      chk(ncmd == 1 && cmd_read === 1'b0 && cmd_index === 4'h0 && cmd_len === 4'h3
         && cmd_data[23:0] === 24'h3380f0, "write");
      m.send(pk(0), '{8'h44}, 1'b0);
      repeat (3) @(posedge mclk);
      chk(ncmd == 1, "classic sum accepted");
      m.send(pk(0), '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09},
         1'b1);
      repeat (3) @(posedge mclk);
      chk(ncmd == 1, "long frame accepted");
   endtask
   task automatic t_stall;
      asg(8'h05, 4'h0, 32'hffffffff);
      m.rdy(1'b0);
      m.hdr(8'h7d);
      repeat (12) @(posedge mclk);
      chk(tx_valid === 1'b1 && m.got.size() == 0, "stall");
      m.rdy(1'b1);
      ans();
   endtask
   task automatic t_refuse;
      m.hdr(8'h7d);
      quiet();
      asg(8'h09, 4'h0, 32'h0);
      chk(pid_table[7:0] === pk(0), "foreign address");
      m.hdr(8'h7d);
      quiet();
      asg(8'h05, 4'h9, {8'hff, pk(1), 16'hffff});
      chk(prep_pending === 1'b0, "missing index");
      m.hdr(8'h7d);
      quiet();
      node_addr = 7'h09;
      asg(8'h09, 4'h0, 32'hffffffff);
      chk(prep_pending === 1'b1, "new own address");
      m.hdr(8'h7d);
      ans();
   endtask
   // ====================
   // Main sequence
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      reset_n = 1'b0;
      fails = 0;
      checked = 0;
      ncmd = 0;
      node_addr = 7'h05;
      addr_valid = 1'b0;
      repeat (16) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      chk(pid_table === 88'h0 && tx_valid === 1'b0 && prep_pending === 1'b0, "reset");
      t_noaddr();
      t_assign();
      t_keep();
      t_read();
      t_write();
      t_stall();
      t_refuse();
      report_and_stop();
   end
endmodule
`default_nettype wire
